/* File: rtl/dac_output_correction_load.sv */
// output code correction (gain, offset, saturation) and converter latch control
// assumes host write strobes and load_strobe are synchronous to ref_clk
// How it works
// - effective gain is (gain_coeff+1)/2^18, never above unity.
// - corrected = output_code/2^17 * gain + offset_coeff/2^17, in full-scale units of the range.
// - overflow clips to the maximum code and underflow to the minimum, never wrapping.
// - with the strobe low, a write starts a calculation and the result loads when done.
// - a strobe falling edge after a write loads the new result even if the strobe rose again.
// - a strobe falling edge after the calculation is done loads the code at that edge.
// - busy is high while calculating; the host waits 2.5 us or polls busy before strobing.
// - output_code is signed two's complement, 0x20000 most negative, 0x1ffff most positive.
// - offset_coeff is signed two's complement, added 1:1 to the output code, so it spans about minus to plus full scale.
// - the 25V setting saturates like the 12.5V setting and flags the fixed 25V offset.
module dac_output_correction_load
   import dac_corr_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire reg_wr_t     host_wr,
   input  wire logic        load_strobe,
   input  wire range_t      range_sel,
   output logic [17:0]      dac_latch_code,
   output logic             dac_latch_load,
   output logic             busy,
   output logic             add_fixed_offset,
   output logic [17:0]      output_code_rd,
   output logic [17:0]      gain_coeff_rd,
   output logic [17:0]      offset_coeff_rd
);
   logic [17:0] output_code_ff;
   logic [17:0] gain_coeff_ff;
   logic [17:0] offset_coeff_ff;
   logic [17:0] hold_code_ff;
   logic        hold_valid_ff;
   logic        pend_edge_ff;
   logic        strobe_d_ff;
   logic [17:0] latch_ff;
   logic        load_ff;
   logic        busy_ff;
   logic        ofs_ff;
   calc_st_t    state_ff;
   logic signed [36:0] prod_ff;
   logic signed [36:0] nxt_prod;
   logic        [18:0] gain_p1;
   logic signed [38:0] sum_ff;
   logic [17:0] nxt_sat;
   logic        any_wr;
   logic        fall;
   logic        calc_done;

   assign any_wr    = host_wr.wr_code | host_wr.wr_gain | host_wr.wr_offset;
   assign fall      = strobe_d_ff & ~load_strobe;
   assign calc_done = (state_ff == ST_SAT);

   // operands widened to 37 bits first so the product is never formed at a narrower width
   assign gain_p1  = {1'b0, gain_coeff_ff} + 19'h00001;
   assign nxt_prod = $signed({{19{output_code_ff[17]}}, output_code_ff}) *
                     $signed({18'h00000, gain_p1});

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         output_code_ff  <= CODE_ZERO;
         gain_coeff_ff   <= GAIN_RESET;
         offset_coeff_ff <= OFFSET_RESET;
      end else begin
         if (host_wr.wr_code)   output_code_ff  <= host_wr.data;
         if (host_wr.wr_gain)   gain_coeff_ff   <= host_wr.data;
         if (host_wr.wr_offset) offset_coeff_ff <= host_wr.data;
      end
   end

   // two-stage calculation (ST_MUL then ST_SAT); a write mid-calculation restarts it with the fresh operands
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         prod_ff  <= '0;
         sum_ff   <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (any_wr) state_ff <= ST_MUL;
            end
            ST_MUL: begin
               prod_ff  <= nxt_prod;
               state_ff <= any_wr ? ST_MUL : ST_SAT;
            end
            ST_SAT: begin
               state_ff <= any_wr ? ST_MUL : ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
         // sum from the product of this same cycle, so the clip stage never sees the last result
         if (state_ff == ST_MUL)
            sum_ff <= 39'(nxt_prod >>> GAIN_SHIFT) + 39'($signed(offset_coeff_ff));
      end
   end

   // clip in the 2^17 code domain so nothing wraps
   always_comb begin
      if (sum_ff > 39'($signed(CODE_MAX)))
         nxt_sat = CODE_MAX;
      else if (sum_ff < 39'($signed(CODE_MIN)))
         nxt_sat = CODE_MIN;
      else
         nxt_sat = sum_ff[17:0];
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= any_wr | (state_ff == ST_MUL) | (calc_done & any_wr);
      end
   end

   // holding register and strobe edge memory
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hold_code_ff  <= CODE_ZERO;
         hold_valid_ff <= 1'b0;
         pend_edge_ff  <= 1'b0;
         // a pin held low after reset looks like one edge, harmless with nothing pending
         strobe_d_ff   <= 1'b1;
      end else begin
         strobe_d_ff <= load_strobe;
         if (calc_done & ~any_wr) begin
            hold_code_ff  <= nxt_sat;
            hold_valid_ff <= 1'b1;
         end else if (load_ff) begin
            hold_valid_ff <= 1'b0;
         end
         // an edge during the calculation is remembered until the result exists
         if (fall & (busy_ff | any_wr) & ~calc_done)
            pend_edge_ff <= 1'b1;
         else if (calc_done & ~any_wr)
            pend_edge_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         latch_ff <= CODE_ZERO;
         load_ff  <= 1'b0;
      end else begin
         // a result finishing with the strobe high waits in the holding register
         load_ff <= 1'b0;
         if (calc_done & ~any_wr & (~load_strobe | pend_edge_ff | fall)) begin
            latch_ff <= nxt_sat;
            load_ff  <= 1'b1;
         end else if (fall & hold_valid_ff) begin
            latch_ff <= hold_code_ff;
            load_ff  <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) ofs_ff <= 1'b0;
      else       ofs_ff <= (range_sel == RANGE_V25);
   end

   assign dac_latch_code   = latch_ff;
   assign dac_latch_load   = load_ff;
   assign busy             = busy_ff;
   assign add_fixed_offset = ofs_ff;
   assign output_code_rd   = output_code_ff;
   assign gain_coeff_rd    = gain_coeff_ff;
   assign offset_coeff_rd  = offset_coeff_ff;

   // busy and calculation timing
   AST_BUSY_ON_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
      any_wr |=> busy)
      else $error("busy not raised after write");
   AST_BUSY_BOUND: assert property (@(posedge ref_clk) disable iff (reset)
      (any_wr ##1 !any_wr [*3]) |-> ##[0:1] !busy)
      else $error("busy too long");
   AST_BUSY_DROP: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff != ST_MUL && !any_wr) |=> !busy)
      else $error("busy high with no calculation");
   AST_STATE_ONEHOT: assert property (@(posedge ref_clk) disable iff (reset)
      $onehot(state_ff))
      else $error("calculation state not one-hot");

   // strobe and latch behaviour
   AST_HOLD_HIGH: assert property (@(posedge ref_clk) disable iff (reset)
      (load_strobe && !pend_edge_ff) |=> $stable(dac_latch_code))
      else $error("latch moved while strobe high");
   AST_HOLD_CAPTURE: assert property (@(posedge ref_clk) disable iff (reset)
      (calc_done && !any_wr) |=> hold_valid_ff && hold_code_ff == $past(nxt_sat))
      else $error("result not kept in holding register");
   AST_FALL_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
      (fall && hold_valid_ff && !calc_done)
      |=> dac_latch_load && dac_latch_code == $past(hold_code_ff))
      else $error("falling edge did not load held code");
   AST_LOW_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
      (calc_done && !any_wr && !load_strobe)
      |=> dac_latch_load && dac_latch_code == $past(nxt_sat))
      else $error("no load with strobe low");
   AST_PEND_SET: assert property (@(posedge ref_clk) disable iff (reset)
      (fall && busy_ff && !calc_done) |=> pend_edge_ff)
      else $error("early strobe edge not remembered");
   AST_PEND_LOAD: assert property (@(posedge ref_clk) disable iff (reset)
      (calc_done && !any_wr && pend_edge_ff) |=> dac_latch_code == $past(nxt_sat))
      else $error("pending edge lost");

   // arithmetic and the 25V offset flag
   AST_CLIP_HI: assert property (@(posedge ref_clk) disable iff (reset)
      (sum_ff > 39'sh1ffff) |-> nxt_sat == 18'h1ffff)
      else $error("no clip high");
   AST_CLIP_LO: assert property (@(posedge ref_clk) disable iff (reset)
      (sum_ff < -39'sh20000) |-> nxt_sat == 18'h20000)
      else $error("no clip low");
   AST_UNITY: assert property (@(posedge ref_clk) disable iff (reset)
      (state_ff == ST_MUL && gain_coeff_ff == 18'h3ffff)
      |=> prod_ff == 37'($signed($past(output_code_ff))) <<< 18)
      else $error("unity gain wrong");
   AST_GAIN_CAP: assert property (@(posedge ref_clk) disable iff (reset)
      (calc_done && !output_code_ff[17])
      |-> (prod_ff >>> 18) <= 37'($signed(output_code_ff)))
      else $error("gain above unity");
   AST_RANGE25: assert property (@(posedge ref_clk) disable iff (reset)
      (range_sel == RANGE_V25) |=> add_fixed_offset)
      else $error("offset flag missing");
endmodule

/* File: rtl/dac_corr_pkg.sv */
// package for the output correction and load control block
// assumes a single 100 MHz clock and synchronous active-high reset
package dac_corr_pkg;
   localparam int CODE_W          = 18;
   localparam int CLK_PERIOD_NS   = 10;
   // host must wait this long after a write before strobing; calculation stays well inside it
   localparam int HOST_WAIT_NS    = 2500;
   localparam int HOST_WAIT_CYC   = HOST_WAIT_NS / CLK_PERIOD_NS;
   localparam int CALC_CYC        = 4;
   localparam logic [2:0] CNT_W3  = 3'h4;
   localparam logic [17:0] CODE_MAX     = 18'h1ffff;
   localparam logic [17:0] CODE_MIN     = 18'h20000;
   localparam logic [17:0] CODE_ZERO    = 18'h00000;
   localparam logic [17:0] GAIN_RESET   = 18'h3ffff;
   localparam logic [17:0] OFFSET_RESET = 18'h00000;
   localparam int GAIN_SHIFT      = 18;

   // output range selection
   typedef enum logic [1:0] {
      RANGE_V12P5 = 2'h0,
      RANGE_V25   = 2'h1,
      RANGE_I25   = 2'h2,
      RANGE_I2P5  = 2'h3
   } range_t;

   // one register write from the host port
   typedef struct packed {
      logic        wr_code;
      logic        wr_gain;
      logic        wr_offset;
      logic [17:0] data;
   } reg_wr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MUL  = 3'b010,
      ST_SAT  = 3'b100
   } calc_st_t;
endpackage

/* File: tb/host_model.sv */
// host side model: coefficient writes and load strobe edges
// assumes every call is made from the ref_clk domain of the bench
module host_model
   import dac_corr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic busy,
   output reg_wr_t   host_wr,
   output logic      load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_wr = '0;
      load_strobe = 1'b0;
   end
   // sel is {code, gain, offset}; the write is taken at the second edge
   task automatic wr(input logic [2:0] sel, input logic [17:0] d);
      @(posedge ref_clk);
      host_wr <= {sel, d};
      @(posedge ref_clk);
      host_wr <= '0;
   endtask
   // a careful host polls busy before the falling edge
   task automatic fall();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(posedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      load_strobe <= 1'b0;
   endtask
   task automatic rise();
      @(posedge ref_clk);
      load_strobe <= 1'b1;
   endtask
   // impatient host: edge lands while the calculation still runs
   task automatic pulse();
      @(posedge ref_clk);
      load_strobe <= 1'b0;
      @(posedge ref_clk);
      load_strobe <= 1'b1;
   endtask
endmodule

/* File: tb/tb_dac_output_correction_load.sv */
// self-checking bench for the output correction and load control
// assumes the host model above drives writes and the strobe
module tb_dac_output_correction_load import dac_corr_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [17:0] c, g, o;} row_t;
   logic ref_clk = 0, reset = 1, busy, add_fixed_offset, dac_latch_load, load_strobe;
   range_t range_sel = RANGE_V12P5;
   reg_wr_t host_wr;
   logic [17:0] dac_latch_code, output_code_rd, gain_coeff_rd, offset_coeff_rd, old;
   int bad_count = 0, checked = 0, cyc = 0, n;
   row_t rows[6] = '{'{18'h1ffff, 18'h3ffff, 18'h00000}, '{18'h20000, 18'h3ffff, 18'h00000},
      '{18'h1ffff, 18'h3ffff, 18'h1ffff}, '{18'h20000, 18'h3ffff, 18'h20000},
      '{18'h10000, 18'h1ffff, 18'h3fff0}, '{18'h1ffff, 18'h00000, 18'h00000}};
   always #5 ref_clk = ~ref_clk;
   dac_output_correction_load i_dac_output_correction_load (
      .ref_clk          (ref_clk),
      .reset            (reset),
      .host_wr          (host_wr),
      .load_strobe      (load_strobe),
      .range_sel        (range_sel),
      .dac_latch_code   (dac_latch_code),
      .dac_latch_load   (dac_latch_load),
      .busy             (busy),
      .add_fixed_offset (add_fixed_offset),
      .output_code_rd   (output_code_rd),
      .gain_coeff_rd    (gain_coeff_rd),
      .offset_coeff_rd  (offset_coeff_rd)
   );
   host_model i_host_model (.ref_clk(ref_clk), .busy(busy), .host_wr(host_wr),
      .load_strobe(load_strobe));
   function automatic logic [17:0] corr(input logic [17:0] c, g, o);
      logic signed [39:0] p;
      p = ($signed({{22{c[17]}}, c}) * $signed({22'h0, g} + 40'h1)) >>> 18;
      p = p + $signed({{22{o[17]}}, o});
      if (p > 131071) return CODE_MAX;
      if (p < -131072) return CODE_MIN;
      return p[17:0];
   endfunction
   task automatic chk(input logic [17:0] got, exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_load(output int k);
      k = 0;
      do begin
         @(posedge ref_clk);
         #1;
         k++;
      end while (dac_latch_load !== 1'b1 && k < 20);
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      chk(gain_coeff_rd, GAIN_RESET);
      chk(dac_latch_code, CODE_ZERO);
      chk(18'(busy), 18'h0);
      foreach (rows[i]) begin
         i_host_model.wr(3'b100, rows[i].c);
         wait_load(n);
         i_host_model.wr(3'b010, rows[i].g);
         wait_load(n);
         i_host_model.wr(3'b001, rows[i].o);
         wait_load(n);
         chk(18'(n), 18'h2);
         chk(offset_coeff_rd, rows[i].o);
         chk(dac_latch_code, corr(rows[i].c, rows[i].g, rows[i].o));
      end
      for (int r = 0; r < 4; r++) begin
         @(posedge ref_clk);
         range_sel <= range_t'(r);
         @(posedge ref_clk);
         #1;
         chk(18'(add_fixed_offset), 18'(r == 1));
      end
      // unity gain first so the held and the new code differ
      i_host_model.wr(3'b010, GAIN_RESET);
      wait_load(n);
      chk(18'(n), 18'h2);
      i_host_model.rise();
      old = dac_latch_code;
      i_host_model.wr(3'b100, 18'h08000);
      @(posedge ref_clk);
      #1;
      chk(18'(busy), 18'h1);
      repeat (10) @(posedge ref_clk);
      #1;
      chk(dac_latch_code, old);
      i_host_model.fall();
      wait_load(n);
      chk(18'(n), 18'h1);
      chk(dac_latch_code, corr(18'h08000, GAIN_RESET, rows[5].o));
      // edge seen in the very cycle the result appears
      i_host_model.rise();
      i_host_model.wr(3'b100, 18'h3f000);
      i_host_model.pulse();
      #1;
      chk(18'(dac_latch_load), 18'h1);
      chk(dac_latch_code, corr(18'h3f000, GAIN_RESET, rows[5].o));
      // edge and return to high both while the calculation still runs
      fork
         i_host_model.wr(3'b100, 18'h04000);
         begin
            @(posedge ref_clk);
            i_host_model.pulse();
         end
      join
      wait_load(n);
      chk(18'(n), 18'h1);
      chk(dac_latch_code, corr(18'h04000, GAIN_RESET, rows[5].o));
      report_and_stop();
   end
endmodule
